//--- include/ctp_pkg.sv
// package: constants and types for the can tx/filter/irq block
package ctp_pkg;
    localparam int NUM_TXB = 3;
    localparam int MSG_BYTES = 13;
    localparam int IDX_W = 2;
    localparam logic [7:0] WARN_LIMIT = 8'h60;
    localparam logic [7:0] PASSIVE_LIMIT = 8'h7f;
    localparam logic [8:0] BUSOFF_LIMIT = 9'h0ff;
    localparam logic [IDX_W-1:0] IDX_NONE = 2'h3;
    localparam logic [7:0] LOCAL_PRIORITY_RESET = 8'hff;
    localparam logic [2:0] HIT_RESET = 3'h0;
    // error flag bit positions
    localparam int EF_OVR = 0;
    localparam int EF_RWRN = 1;
    localparam int EF_TWRN = 2;
    localparam int EF_RERR = 3;
    localparam int EF_TERR = 4;
    localparam int EF_BOFF = 5;
    localparam int EF_W = 6;

    typedef enum logic [1:0] {
        CTP_F32 = 2'h0,
        CTP_F16 = 2'h1,
        CTP_F8 = 2'h2,
        CTP_FCLOSED = 2'h3
    } ctp_fmode_e;

    typedef enum logic [2:0] {
        CTP_IDLE = 3'b001,
        CTP_SEND = 3'b010,
        CTP_DONE = 3'b100
    } ctp_txst_e;

    // message image: 13 bytes, byte 0..3 hold the identifier layout
    typedef struct packed {
        logic [MSG_BYTES*8-1:0] image;
    } ctp_msg_s;

    // one tx buffer as loaded by the host
    typedef struct packed {
        ctp_msg_s msg;
        logic [7:0] local_priority;
    } ctp_txbuf_s;

    // protocol engine error counters
    typedef struct packed {
        logic [7:0] rx_cnt;
        logic [8:0] tx_cnt;
    } ctp_errcnt_s;
endpackage : ctp_pkg

//--- logic/ctp_core.sv
// can transmit prioritiser, acceptance filter and interrupt flags
`timescale 1ns/1ps
module ctp_core (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // host side: buffer load and handshakes
    input wire logic [ctp_pkg::NUM_TXB-1:0] buf_write,
    input wire ctp_pkg::ctp_txbuf_s buf_data,
    input wire logic [ctp_pkg::NUM_TXB-1:0] empty_clear,
    input wire logic [ctp_pkg::NUM_TXB-1:0] abort_request,
    input wire logic [ctp_pkg::NUM_TXB-1:0] tx_empty_mask,
    input wire logic rx_full_clear,
    input wire logic rx_full_mask,
    input wire logic wake_clear,
    input wire logic wake_mask,
    input wire logic [ctp_pkg::EF_W-1:0] err_clear,
    input wire logic [ctp_pkg::EF_W-1:0] err_mask,
    input wire ctp_pkg::ctp_fmode_e filter_mode,
    input wire logic [63:0] acceptance_pattern_regs,
    input wire logic [63:0] acceptance_mask_regs,
    // protocol engine side
    input wire logic arb_start,
    input wire logic tx_success,
    input wire logic tx_error,
    input wire logic frame_received,
    input wire ctp_pkg::ctp_msg_s rx_msg,
    input wire ctp_pkg::ctp_errcnt_s err_counts,
    input wire logic sleep_state,
    input wire logic rx_pin,
    input wire logic tx_ready,
    // outputs
    output logic tx_valid,
    output ctp_pkg::ctp_msg_s tx_msg,
    output logic [ctp_pkg::NUM_TXB-1:0] tx_buffer_empty,
    output logic [ctp_pkg::NUM_TXB-1:0] abort_acknowledge,
    output logic rx_full,
    output ctp_pkg::ctp_msg_s rx_host_buffer,
    output logic [2:0] filter_hit_index,
    output logic [ctp_pkg::EF_W-1:0] err_flags,
    output logic wake_flag,
    output logic irq_tx,
    output logic irq_rx,
    output logic irq_wake,
    output logic irq_err
);
    import ctp_pkg::*;

    // storage and state
    ctp_txbuf_s bufs [NUM_TXB];
    logic [NUM_TXB-1:0] next_tx_buffer_empty, next_abort_acknowledge;
    ctp_txst_e tx_state, next_tx_state;
    logic [IDX_W-1:0] active_idx, next_active_idx;
    logic rx_sync1, rx_sync2, rx_prev;
    // two-entry output buffer between scheduler and engine
    ctp_msg_s ob_data [2];
    logic [1:0] ob_cnt, next_ob_cnt;
    logic ob_wr, ob_rd, ob_rptr, ob_wptr;
    // receive path
    ctp_msg_s shadow, next_shadow, next_rx_host_buffer;
    logic shadow_full, next_shadow_full, next_rx_full;
    logic [2:0] next_filter_hit_index;
    logic [7:0] hits;
    logic any_hit;
    logic [2:0] low_hit;
    logic [EF_W-1:0] err_cond, next_err_flags;
    logic next_wake_flag, ovr_event;
    logic [2:0] shadow_hit, next_shadow_hit;

    // buffer images are written by the host only while the buffer is empty
    always_ff @(posedge clk) begin
        if (clk_en) begin
            for (int i = 0; i < NUM_TXB; i++) begin
                if (buf_write[i] && tx_buffer_empty[i]) begin
                    bufs[i] <= buf_data;
                end
            end
        end
    end

    // choose the pending buffer with lowest priority value, lowest index on ties
    logic [IDX_W-1:0] pick;
    logic [7:0] pick_local_priority;
    logic pick_ok;
    always_comb begin
        pick = IDX_NONE;
        pick_local_priority = LOCAL_PRIORITY_RESET;
        pick_ok = 1'b0;
        for (int i = 0; i < NUM_TXB; i++) begin
            if (!tx_buffer_empty[i] && !abort_request[i]
                && (!pick_ok || bufs[i].local_priority < pick_local_priority)) begin
                pick = IDX_W'(i);
                pick_local_priority = bufs[i].local_priority;
                pick_ok = 1'b1;
            end
        end
    end

    // transmit scheduler state
    always_comb begin
        next_tx_state = tx_state;
        next_active_idx = active_idx;
        next_tx_buffer_empty = tx_buffer_empty;
        next_abort_acknowledge = abort_acknowledge;
        ob_wr = 1'b0;
        unique case (tx_state)
            CTP_IDLE: begin
                // selection is made anew at each arbitration, retries included
                if (arb_start && pick_ok && ob_cnt < 2'h2) begin
                    next_active_idx = pick;
                    next_tx_state = CTP_SEND;
                    ob_wr = 1'b1;
                end
            end
            CTP_SEND: begin
                if (tx_success) begin
                    next_tx_buffer_empty[active_idx] = 1'b1;
                    next_abort_acknowledge[active_idx] = 1'b0;
                    next_tx_state = CTP_DONE;
                end else if (tx_error) begin
                    next_tx_state = CTP_IDLE;
                end
            end
            CTP_DONE: begin
                next_tx_state = CTP_IDLE;
            end
            default: begin
                next_tx_state = CTP_IDLE; // an illegal one-hot code falls back to idle
            end
        endcase
        for (int i = 0; i < NUM_TXB; i++) begin
            // host marks buffer ready; clears acknowledge for the new message
            if (empty_clear[i] && tx_buffer_empty[i]) begin
                next_tx_buffer_empty[i] = 1'b0;
                next_abort_acknowledge[i] = 1'b0;
            end
            // abort granted only if not the message on the bus
            if (abort_request[i] && !tx_buffer_empty[i]
                && !(tx_state == CTP_SEND && active_idx == IDX_W'(i))) begin
                next_tx_buffer_empty[i] = 1'b1;
                next_abort_acknowledge[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_state <= CTP_IDLE;
            active_idx <= IDX_NONE;
            tx_buffer_empty <= '1;
            abort_acknowledge <= '0;
        end else if (clk_en) begin
            tx_state <= next_tx_state;
            active_idx <= next_active_idx;
            tx_buffer_empty <= next_tx_buffer_empty;
            abort_acknowledge <= next_abort_acknowledge;
        end
    end

    // two-entry buffer toward the protocol engine
    assign ob_rd = tx_valid && tx_ready;
    always_comb begin
        next_ob_cnt = ob_cnt + (ob_wr ? 2'h1 : 2'h0) - (ob_rd ? 2'h1 : 2'h0);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ob_cnt <= 2'h0;
            ob_rptr <= 1'b0;
            ob_wptr <= 1'b0;
            tx_valid <= 1'b0;
            tx_msg <= '0;
        end else if (clk_en) begin
            ob_cnt <= next_ob_cnt;
            if (ob_wr) begin
                ob_data[ob_wptr] <= bufs[pick].msg;
                ob_wptr <= ~ob_wptr;
            end
            if (ob_rd) begin
                ob_rptr <= ~ob_rptr;
            end
            tx_valid <= next_ob_cnt != 2'h0;
            if (next_ob_cnt != 2'h0) begin
                tx_msg <= (ob_rd || ob_cnt == 2'h0)
                    ? ((ob_cnt == 2'h2 || (ob_cnt == 2'h1 && !ob_rd)) ? ob_data[~ob_rptr]
                       : (ob_wr ? bufs[pick].msg : ob_data[~ob_rptr]))
                    : ob_data[ob_rptr];
            end
        end
    end

    // acceptance filter: one comparator per pattern bit and filter width; mask 1 ignores it
    logic [63:0] ok32, ok16, ok8;
    logic [31:0] idw;
    assign idw = rx_msg.image[MSG_BYTES*8-1 -: 32];
    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_cmp
            // wide filters see the whole word, narrow filters only its top bits
            assign ok32[g] = acceptance_mask_regs[g]
                | (acceptance_pattern_regs[g] ~^ idw[g % 32]);
            assign ok16[g] = acceptance_mask_regs[g]
                | (acceptance_pattern_regs[g] ~^ idw[16 + g % 16]);
            assign ok8[g] = acceptance_mask_regs[g]
                | (acceptance_pattern_regs[g] ~^ idw[24 + g % 8]);
        end
    endgenerate

    always_comb begin
        hits = 8'h00;
        unique case (filter_mode)
            CTP_F32: begin
                hits[0] = &ok32[31:0];
                hits[1] = &ok32[63:32];
            end
            CTP_F16: begin
                // each half checks the top 16 bits: 11 id + rtr, or 16 top extended bits
                hits[0] = &ok16[31:16];
                hits[1] = &ok16[15:0];
                hits[2] = &ok16[63:48];
                hits[3] = &ok16[47:32];
            end
            CTP_F8: begin
                // filters 0 to 3 come from bank 0, highest byte first; 4 to 7 from bank 1
                for (int k = 0; k < 8; k++) begin
                    hits[k] = &ok8[(32*(k/4) + 8*(3-(k%4)) + 7) -: 8];
                end
            end
            CTP_FCLOSED: begin
                hits = 8'h00;
            end
        endcase
        any_hit = |hits;
        low_hit = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (hits[k]) begin
                low_hit = 3'(k);
            end
        end
    end

    // receive storage, error and wake flags
    assign err_cond[EF_OVR] = 1'b0;
    assign err_cond[EF_RWRN] = err_counts.rx_cnt >= WARN_LIMIT;
    assign err_cond[EF_TWRN] = err_counts.tx_cnt >= {1'b0, WARN_LIMIT};
    assign err_cond[EF_RERR] = err_counts.rx_cnt > PASSIVE_LIMIT;
    assign err_cond[EF_TERR] = err_counts.tx_cnt > {1'b0, PASSIVE_LIMIT};
    assign err_cond[EF_BOFF] = err_counts.tx_cnt > BUSOFF_LIMIT;
    assign ovr_event = frame_received && any_hit && rx_full && shadow_full;

    always_comb begin
        next_shadow = shadow;
        next_shadow_full = shadow_full;
        next_rx_full = rx_full;
        next_rx_host_buffer = rx_host_buffer;
        next_filter_hit_index = filter_hit_index;
        next_shadow_hit = shadow_hit;
        if (rx_full_clear && rx_full) begin
            if (shadow_full) begin
                // the waiting message brings its own hit number along
                next_rx_host_buffer = shadow;
                next_filter_hit_index = shadow_hit;
                next_shadow_full = 1'b0;
            end else begin
                next_rx_full = 1'b0;
            end
        end
        if (frame_received && any_hit && !ovr_event) begin
            if (!next_rx_full) begin
                next_rx_host_buffer = rx_msg;
                next_rx_full = 1'b1;
                next_filter_hit_index = low_hit;
            end else begin
                next_shadow = rx_msg;
                next_shadow_hit = low_hit;
                next_shadow_full = 1'b1;
            end
        end
        // write 1 clears unless the condition or a new event holds
        next_err_flags = (err_flags & ~err_clear) | err_cond;
        next_err_flags[EF_OVR] = ovr_event | (err_flags[EF_OVR] & ~err_clear[EF_OVR]);
        next_wake_flag = (sleep_state && rx_sync2 != rx_prev)
            | (wake_flag & ~wake_clear);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shadow <= '0;
            shadow_full <= 1'b0;
            rx_full <= 1'b0;
            rx_host_buffer <= '0;
            filter_hit_index <= HIT_RESET;
            shadow_hit <= HIT_RESET;
            err_flags <= '0;
            wake_flag <= 1'b0;
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
            rx_prev <= 1'b1;
            irq_tx <= 1'b0;
            irq_rx <= 1'b0;
            irq_wake <= 1'b0;
            irq_err <= 1'b0;
        end else if (clk_en) begin
            shadow <= next_shadow;
            shadow_full <= next_shadow_full;
            rx_full <= next_rx_full;
            rx_host_buffer <= next_rx_host_buffer;
            filter_hit_index <= next_filter_hit_index;
            shadow_hit <= next_shadow_hit;
            err_flags <= next_err_flags;
            wake_flag <= next_wake_flag;
            rx_sync1 <= rx_pin;
            rx_sync2 <= rx_sync1;
            rx_prev <= rx_sync2;
            // eleven sources, each masked, onto four outputs
            irq_tx <= |(next_tx_buffer_empty & ~tx_empty_mask);
            irq_rx <= next_rx_full & ~rx_full_mask;
            irq_wake <= next_wake_flag & ~wake_mask;
            irq_err <= |(next_err_flags & ~err_mask);
        end
    end

    // transmit scheduler, abort, closed filter, hit, bus-off and tx interrupt checks, plus covers
    AST_ABORT_ACK: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && abort_request[0] && !tx_buffer_empty[0] && !(tx_state == CTP_SEND
        && active_idx == 2'h0) |=> tx_buffer_empty[0] && abort_acknowledge[0])
        else $error("abort not granted");
    AST_NO_ABORT_ACTIVE: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && tx_state == CTP_SEND && active_idx == 2'h0 && !tx_success
        && !tx_buffer_empty[0] |=> !tx_buffer_empty[0])
        else $error("active buffer released");
    AST_SENT_ACK: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && tx_state == CTP_SEND && tx_success |=> tx_buffer_empty[active_idx]
        && !abort_acknowledge[$past(active_idx)])
        else $error("sent buffer wrong acknowledge");
    AST_CLOSED: assert property (@(posedge clk) disable iff (!reset_n)
        filter_mode == CTP_FCLOSED && !rx_full |=> !rx_full || !$past(clk_en))
        else $error("closed filter stored");
    AST_LOCAL_PRIORITY: assert property (@(posedge clk) disable iff (!reset_n)
        pick_ok |-> bufs[pick].local_priority <= bufs[0].local_priority
        || tx_buffer_empty[0] || abort_request[0])
        else $error("priority pick wrong");
    AST_HIT: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && frame_received && any_hit && !rx_full |=> rx_full
        && filter_hit_index == $past(low_hit))
        else $error("hit not stored");
    AST_BOFF: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && err_counts.tx_cnt > BUSOFF_LIMIT |=> err_flags[EF_BOFF])
        else $error("bus-off not flagged");
    AST_IRQ_TX: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en ##1 (tx_buffer_empty & ~$past(tx_empty_mask)) != 3'h0 |-> irq_tx)
        else $error("tx interrupt missing");
    COV_SEND: cover property (@(posedge clk) tx_state == CTP_SEND ##[1:20] tx_success);
    COV_ABORT: cover property (@(posedge clk) abort_acknowledge[1]);
    COV_OVR: cover property (@(posedge clk) ovr_event);
    COV_STALL: cover property (@(posedge clk) tx_valid && !tx_ready);
    COV_MULTI_HIT: cover property (@(posedge clk) frame_received && hits[0] && hits[1]);
    // receive, wake and error flag checks
    AST_WAKE: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && sleep_state && rx_sync2 != rx_prev |=> wake_flag)
        else $error("wake-up not flagged");
    AST_TWRN: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && err_counts.tx_cnt >= {1'b0, WARN_LIMIT} |=> err_flags[EF_TWRN])
        else $error("tx warning not flagged");
    AST_RERR: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && err_counts.rx_cnt > PASSIVE_LIMIT |=> err_flags[EF_RERR])
        else $error("rx passive not flagged");
    AST_IRQ_RX: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && frame_received && any_hit && !rx_full && !rx_full_mask |=> irq_rx)
        else $error("rx interrupt missing");
    AST_OVR: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && frame_received && any_hit && rx_full && shadow_full |=> err_flags[EF_OVR])
        else $error("overrun not flagged");
endmodule : ctp_core

//--- sim/ctp_engine_model.sv
// protocol engine stand-in that takes transmit words from the block's output buffer
`timescale 1ns/1ps
module ctp_engine_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic tx_valid,
    input wire ctp_pkg::ctp_msg_s tx_msg,
    output logic tx_ready,
    output ctp_pkg::ctp_msg_s got_msg,
    output int got_cnt
);
    import ctp_pkg::*;

    // ready follows the stall request one edge late, so a stall really backs up the buffer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_ready <= 1'b0;
            got_cnt <= 0;
            got_msg <= '0;
        end else begin
            tx_ready <= !stall;
            // a word is taken only at an edge where valid and ready are both high
            if (tx_valid && tx_ready) begin
                got_msg <= tx_msg;
                got_cnt <= got_cnt + 1;
            end
        end
    end
endmodule : ctp_engine_model

//--- sim/tb_top.sv
// self-checking bench for the transmit prioritiser, acceptance filter and interrupt block
`timescale 1ns/1ps
`define CHK(act, exp) begin \
    n_checks++; \
    if ((act) !== (exp)) begin \
        n_errors++; \
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (act), (exp)); \
    end \
end
module tb_top;
    import ctp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] buf_write = '0, empty_clear = '0, abort_request = '0, tx_empty_mask = '0;
    logic rx_full_clear = 1'b0, rx_full_mask = 1'b0, wake_clear = 1'b0, wake_mask = 1'b0;
    logic [5:0] err_clear = '0, err_mask = '0;
    ctp_fmode_e filter_mode = CTP_F32;
    logic [63:0] pat = '0, msk = '0;
    logic arb_start = 1'b0, tx_success = 1'b0, tx_error = 1'b0, frame_received = 1'b0;
    logic sleep_state = 1'b0, rx_pin = 1'b1, tx_ready, stall = 1'b0, tx_valid, rx_full;
    ctp_txbuf_s buf_data = '0;
    ctp_msg_s rx_msg = '0, tx_msg, got_msg, rx_host;
    ctp_errcnt_s err_counts = '0;
    logic [2:0] tx_buffer_empty, abort_acknowledge, filter_hit_index;
    logic [5:0] err_flags;
    logic wake_flag, irq_tx, irq_rx, irq_wake, irq_err;
    int got_cnt, n_errors = 0, n_checks = 0;
    logic [31:0] id = 32'h5a3c_c3a5;
    logic [1:0] fm [9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    logic [63:0] fp [9] = '{64'h5a3cc3a5_5a3cc3a5, 64'h5a3cc3a5_a5c33c5a,
        64'ha5c33c5a_5a3cc3a4, 64'ha5c35a3c_a5c3a5c3, 64'h5a3ca5c3_a5c35a3c,
        64'ha5a55aa5_a5a5a5a5, 64'ha5a5a5a5_a5a5a5a5, 64'h5a3cc3a5_5a3cc3a5,
        64'ha5c33c5a_a5c33c5a};
    logic [63:0] fk [9] = '{64'h0, 64'h0, 64'h1, 64'h0, 64'h0, 64'h0, 64'hff,
        64'hffffffff_ffffffff, 64'h0};
    logic [3:0] fe [9] = '{4'h8, 4'h9, 4'h8, 4'hb, 4'h9, 4'he, 4'hb, 4'h0, 4'h0};
    logic [8:0] rxc [6] = '{9'd95, 9'd96, 9'd96, 9'd128, 9'd128, 9'd128};
    logic [8:0] txc [6] = '{9'd0, 9'd0, 9'd96, 9'd96, 9'd128, 9'd256};
    logic [5:0] efl [6] = '{6'h00, 6'h02, 6'h06, 6'h0e, 6'h1e, 6'h3e};

    // 40 MHz clock
    always #12.5 clk = ~clk;

    ctp_core i_ctp_core (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .buf_write(buf_write), .buf_data(buf_data), .empty_clear(empty_clear),
        .abort_request(abort_request), .tx_empty_mask(tx_empty_mask),
        .rx_full_clear(rx_full_clear), .rx_full_mask(rx_full_mask), .wake_clear(wake_clear),
        .wake_mask(wake_mask), .err_clear(err_clear), .err_mask(err_mask),
        .filter_mode(filter_mode), .acceptance_pattern_regs(pat),
        .acceptance_mask_regs(msk), .arb_start(arb_start), .tx_success(tx_success),
        .tx_error(tx_error), .frame_received(frame_received), .rx_msg(rx_msg),
        .err_counts(err_counts), .sleep_state(sleep_state), .rx_pin(rx_pin),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_msg(tx_msg),
        .tx_buffer_empty(tx_buffer_empty), .abort_acknowledge(abort_acknowledge),
        .rx_full(rx_full), .rx_host_buffer(rx_host), .filter_hit_index(filter_hit_index),
        .err_flags(err_flags), .wake_flag(wake_flag), .irq_tx(irq_tx), .irq_rx(irq_rx),
        .irq_wake(irq_wake), .irq_err(irq_err));

    ctp_engine_model i_ctp_engine_model (.clk(clk), .reset_n(reset_n), .stall(stall),
        .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_ready(tx_ready), .got_msg(got_msg),
        .got_cnt(got_cnt));

    // inputs move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    function automatic logic [103:0] img(input int i);
        img = {13{8'(8'h11 * (i + 1))}};
    endfunction : img

    // host fills an empty buffer, then hands it over by clearing its empty flag
    task automatic load(input int i, input logic [7:0] p);
        buf_data.msg.image = img(i);
        buf_data.local_priority = p;
        buf_write[i] = 1'b1;
        tick(1);
        buf_write = '0;
        empty_clear[i] = 1'b1;
        tick(1);
        empty_clear = '0;
        tick(2);
    endtask : load

    // one arbitration: optional engine stall, optional abort while on the bus, then outcome
    task automatic send(input int i, input logic ok, input int st, input logic ab);
        int c;
        c = got_cnt;
        stall = (st != 0);
        arb_start = 1'b1;
        tick(1);
        arb_start = 1'b0;
        if (st != 0) begin
            tick(st);
            `CHK(tx_valid, 1'b1)
            `CHK(tx_msg.image, img(i))
            stall = 1'b0;
        end
        for (int w = 0; w < 50 && got_cnt == c; w++) tick(1);
        `CHK(got_msg.image, img(i))
        if (ab) abort_request[i] = 1'b1;
        tick(2);
        if (ok) tx_success = 1'b1;
        else tx_error = 1'b1;
        tick(1);
        tx_success = 1'b0;
        tx_error = 1'b0;
        tick(3);
    endtask : send

    // a received frame carrying the test identifier
    task automatic frame();
        rx_msg.image = {id, 72'h0};
        frame_received = 1'b1;
        tick(1);
        frame_received = 1'b0;
        tick(3);
    endtask : frame

    task automatic close_out();
        $display("errors=%0d checks=%0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        n_errors++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        tick(2);
        `CHK(tx_buffer_empty, 3'h7)
        `CHK(irq_tx, 1'b1)
        load(0, 8'h20);
        load(1, 8'h10);
        `CHK(tx_buffer_empty, 3'h4)
        send(1, 1'b0, 0, 1'b0);
        load(2, 8'h05);
        send(2, 1'b1, 0, 1'b0);
        `CHK(tx_buffer_empty, 3'h4)
        abort_request[0] = 1'b1;
        tick(3);
        `CHK(abort_acknowledge[0], 1'b1)
        `CHK(tx_buffer_empty, 3'h5)
        abort_request = '0;
        send(1, 1'b1, 0, 1'b1);
        `CHK(abort_acknowledge[1], 1'b0)
        `CHK(tx_buffer_empty, 3'h7)
        abort_request = '0;
        load(1, 8'h40);
        load(2, 8'h40);
        send(1, 1'b1, 0, 1'b0);
        send(2, 1'b1, 4, 1'b0);
        `CHK(irq_tx, 1'b1)
        tx_empty_mask = 3'h7;
        tick(2);
        `CHK(irq_tx, 1'b0)
        // acceptance filter in every mode
        for (int e = 0; e < 9; e++) begin
            filter_mode = ctp_fmode_e'(fm[e]);
            pat = fp[e];
            msk = fk[e];
            tick(1);
            frame();
            `CHK(rx_full, fe[e][3])
            if (fe[e][3]) begin
                `CHK(filter_hit_index, fe[e][2:0])
                `CHK(rx_host.image, {id, 72'h0})
                `CHK(irq_rx, 1'b1)
            end
            rx_full_clear = 1'b1;
            tick(1);
            rx_full_clear = 1'b0;
            tick(2);
        end
        // three accepted frames with nobody reading: overrun
        filter_mode = CTP_F32;
        pat = fp[0];
        msk = '0;
        repeat (3) frame();
        `CHK(err_flags[EF_OVR], 1'b1)
        `CHK(irq_err, 1'b1)
        rx_full_clear = 1'b1;
        tick(1);
        rx_full_clear = 1'b0;
        tick(2);
        `CHK(rx_full, 1'b1)
        err_clear = 6'h01;
        tick(1);
        err_clear = '0;
        tick(2);
        `CHK(err_flags, 6'h00)
        // error counter limits, flags accumulate
        for (int e = 0; e < 6; e++) begin
            err_counts.rx_cnt = rxc[e][7:0];
            err_counts.tx_cnt = txc[e];
            tick(3);
            `CHK(err_flags, efl[e])
        end
        err_clear = 6'h3f;
        tick(1);
        err_clear = '0;
        tick(2);
        `CHK(err_flags, 6'h3e)
        err_counts = '0;
        tick(2);
        err_clear = 6'h3f;
        tick(1);
        err_clear = '0;
        tick(2);
        `CHK(err_flags, 6'h00)
        // bus activity while asleep
        sleep_state = 1'b1;
        rx_pin = 1'b0;
        tick(5);
        `CHK(wake_flag, 1'b1)
        `CHK(irq_wake, 1'b1)
        wake_mask = 1'b1;
        tick(2);
        `CHK(irq_wake, 1'b0)
        sleep_state = 1'b0;
        rx_pin = 1'b1;
        tick(3);
        wake_clear = 1'b1;
        tick(1);
        wake_clear = 1'b0;
        tick(2);
        `CHK(wake_flag, 1'b0)
        // a clear offered while the clock enable is low must be ignored
        clk_en = 1'b0;
        rx_full_clear = 1'b1;
        tick(1);
        rx_full_clear = 1'b0;
        clk_en = 1'b1;
        tick(2);
        `CHK(rx_full, 1'b1)
        rx_full_clear = 1'b1;
        tick(1);
        rx_full_clear = 1'b0;
        tick(2);
        `CHK(rx_full, 1'b0)
        `CHK(irq_rx, 1'b0)
        close_out();
    end
endmodule : tb_top
